// File: bench/hp_spk_chk_sva.sv
// Checker for the speaker and headphone control block
// Assumes it is bound to the top module ports
`timescale 1ns/100ps
module hp_spk_chk (
  // Clock, reset, bus
  input wire logic mclk,
  input wire logic rst_n,
  input wire spk_hp_pkg::wb_req_type wb_req,
  input wire logic wb_ack_o,
  // Speaker
  input wire logic [15:0] spk_left_in,
  input wire logic [15:0] spk_right_in,
  input wire logic [15:0] spk_left_drive,
  input wire logic [15:0] spk_right_drive,
  input wire spk_hp_pkg::speaker_ctrl_type spk_left_ctrl,
  input wire spk_hp_pkg::speaker_ctrl_type spk_right_ctrl,
  // Headphone
  input wire logic left_input_stage_en,
  input wire logic left_phones_out_short
);
  import spk_hp_pkg::*;
  logic wr;
  assign wr = wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] & !wb_ack_o;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_ack_answer:
    assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_boost_write:
    assert property (wr && wb_req.adr == 32'hcc |=> spk_left_ctrl.speaker_ac_boost == $past(wb_req.dat[2:0]))
    else $error("boost not written");
  chk_mono_route:
    assert property (rst_n && spk_left_ctrl.mono_speaker_select |=> spk_right_drive == $past(spk_left_in))
    else $error("mono route wrong");
  chk_stereo_route:
    assert property (rst_n && !spk_left_ctrl.mono_speaker_select |=> spk_right_drive == $past(spk_right_in))
    else $error("stereo route wrong");
  chk_left_drive:
    assert property (rst_n |=> spk_left_drive == $past(spk_left_in)) else $error("left drive wrong");
  chk_ctrl_equal:
    assert property (spk_left_ctrl == spk_right_ctrl) else $error("channel controls differ");
  chk_gain_decode:
    assert property (spk_left_ctrl.boost_gain_half_db == (spk_left_ctrl.speaker_ac_boost == 3'h7 ? 5'h18 :
      {2'h0, spk_left_ctrl.speaker_ac_boost} * 5'h3)) else $error("gain decode wrong");
  chk_hp_write:
    assert property (wr && wb_req.adr == 32'h114 |=> left_phones_out_short == !$past(wb_req.dat[7]) &&
      left_input_stage_en == $past(wb_req.dat[4])) else $error("headphone bits wrong");
endmodule

// File: bench/hp_spk_output_stage_ctrl_bench.sv
// Bench for the speaker and headphone control block
// Assumes classic Wishbone, one cycle answer
`timescale 1ns/100ps
module hp_spk_output_stage_ctrl_bench;
  import spk_hp_pkg::*;
  logic mclk = 0;
  logic rst_n = 0;
  wb_req_type wb_req = '0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o;
  logic [15:0] spk_left_in = '0, spk_right_in = '0, spk_left_drive, spk_right_drive;
  speaker_ctrl_type spk_left_ctrl, spk_right_ctrl;
  logic left_input_stage_en, left_middle_stage_en, left_output_stage_en, left_phones_out_short;
  logic right_input_stage_en, right_middle_stage_en, right_output_stage_en, right_phones_out_short;
  int n_errors = 0;
  int checked = 0;
  // Address, write data, expected read
  logic [31:0] rows [6][3] = '{'{32'hcc, 32'h47, 32'h47}, '{32'hcc, 32'hff, 32'h47}, '{32'h114, 32'h1ff, 32'hff},
    '{32'h40, 32'hff, 32'h0}, '{32'h114, 32'ha5, 32'ha5}, '{32'hcc, 32'h40, 32'h40}};
  // 20 us at 8 ns per cycle
  localparam int hp_settle = 2500;
  hp_spk_output_stage_ctrl DUT (
    .mclk(mclk),
    .rst_n(rst_n),
    .wb_req(wb_req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .spk_left_in(spk_left_in),
    .spk_right_in(spk_right_in),
    .spk_left_drive(spk_left_drive),
    .spk_right_drive(spk_right_drive),
    .spk_left_ctrl(spk_left_ctrl),
    .spk_right_ctrl(spk_right_ctrl),
    .left_input_stage_en(left_input_stage_en),
    .left_middle_stage_en(left_middle_stage_en),
    .left_output_stage_en(left_output_stage_en),
    .left_phones_out_short(left_phones_out_short),
    .right_input_stage_en(right_input_stage_en),
    .right_middle_stage_en(right_middle_stage_en),
    .right_output_stage_en(right_output_stage_en),
    .right_phones_out_short(right_phones_out_short)
  );
  always #4 mclk = ~mclk;
  // Stage outputs as a register image
  function automatic logic [31:0] hp_image();
    hp_image = {24'h0, ~left_phones_out_short, left_output_stage_en, left_middle_stage_en, left_input_stage_en,
      ~right_phones_out_short, right_output_stage_en, right_middle_stage_en, right_input_stage_en};
  endfunction
  task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    n = 0;
    wb_req <= '{d, a, s, w, 1'b1, 1'b1};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      print_verdict;
    end
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge mclk);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cmp("shorts", 32'h3, {left_phones_out_short, right_phones_out_short});
    wb(1'b0, 32'hcc, 32'h0, 4'hf);
    cmp("spk reset", 32'h3, rd);
    wb(1'b0, 32'h114, 32'h0, 4'hf);
    cmp("hp reset", 32'h0, rd);
    foreach (rows[i]) begin
      wb(1'b1, rows[i][0], rows[i][1], 4'hf);
      wb(1'b0, rows[i][0], 32'h0, 4'hf);
      cmp("readback", rows[i][2], rd);
    end
    cmp("hp stages", 32'h2d, {left_phones_out_short, left_output_stage_en, left_middle_stage_en,
      left_input_stage_en, right_phones_out_short, right_output_stage_en, right_middle_stage_en, right_input_stage_en});
    spk_left_in <= 16'h1234;
    spk_right_in <= 16'h5678;
    repeat (2) @(posedge mclk);
    cmp("mono drive", 32'h1234, spk_right_drive);
    cmp("right ctrl", 32'h100, spk_right_ctrl);
    wb(1'b1, 32'hcc, 32'h7, 4'h0);
    wb(1'b0, 32'hcc, 32'h0, 4'hf);
    cmp("no lane write", 32'h40, rd);
    wb(1'b1, 32'hcc, 32'h7, 4'hf);
    @(posedge mclk);
    cmp("stereo drive", 32'h5678, spk_right_drive);
    cmp("top gain", 32'hf8, spk_right_ctrl);
    // Reset in mid-run brings back every reset value
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cmp("reset ctrl", 32'h69, spk_right_ctrl);
    cmp("reset shorts", 32'h3, {left_phones_out_short, right_phones_out_short});
    wb(1'b0, 32'hcc, 32'h0, 4'hf);
    cmp("spk re-reset", 32'h3, rd);
    wb(1'b0, 32'h114, 32'h0, 4'hf);
    cmp("hp re-reset", 32'h0, rd);
    // Enable order with settle times, then shut-down order
    wb(1'b1, 32'h114, 32'h11, 4'hf);
    cmp("input stages", 32'h11, hp_image());
    repeat (hp_settle) @(posedge mclk);
    wb(1'b1, 32'h114, 32'h33, 4'hf);
    cmp("middle stages", 32'h33, hp_image());
    wb(1'b1, 32'h114, 32'h77, 4'hf);
    cmp("output stages", 32'h77, hp_image());
    cmp("still shorted", 32'h3, {left_phones_out_short, right_phones_out_short});
    repeat (hp_settle) @(posedge mclk);
    wb(1'b1, 32'h114, 32'hff, 4'hf);
    cmp("shorts released", 32'h0, {left_phones_out_short, right_phones_out_short});
    wb(1'b0, 32'h114, 32'h0, 4'hf);
    cmp("hp enabled", 32'hff, rd);
    wb(1'b1, 32'h114, 32'h77, 4'hf);
    cmp("shorts back", 32'h3, {left_phones_out_short, right_phones_out_short});
    repeat (hp_settle) @(posedge mclk);
    wb(1'b1, 32'h114, 32'h0, 4'hf);
    cmp("all stages off", 32'h0, hp_image());
    print_verdict;
  end
endmodule
bind hp_spk_output_stage_ctrl hp_spk_chk chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .wb_req(wb_req),
  .wb_ack_o(wb_ack_o),
  .spk_left_in(spk_left_in),
  .spk_right_in(spk_right_in),
  .spk_left_drive(spk_left_drive),
  .spk_right_drive(spk_right_drive),
  .spk_left_ctrl(spk_left_ctrl),
  .spk_right_ctrl(spk_right_ctrl),
  .left_input_stage_en(left_input_stage_en),
  .left_phones_out_short(left_phones_out_short)
);

// File: hdl/hp_channel_stage.sv
// One headphone channel: stage enables and output short switch
// Assumes fields come straight from registers on the same clock
`timescale 1ns/100ps
module hp_channel_stage (
  // Field from register
  input wire spk_hp_pkg::hp_channel_type fields,
  // Analogue controls
  output logic input_stage_on,
  output logic middle_stage_on,
  output logic output_stage_on,
  output logic short_to_ground
);
  import spk_hp_pkg::*;

  always_comb begin
    input_stage_on = fields.input_stage_en; // see R15
    middle_stage_on = fields.middle_stage_en; // see R15
    output_stage_on = fields.output_stage_en; // see R15
    short_to_ground = ~fields.short_release; // see R6
  end
endmodule

// File: hdl/hp_spk_output_stage_ctrl.sv
// Speaker driver configuration and headphone stage control registers
// Assumes a classic Wishbone master on mclk; controls drive analogue stages
//
// Summary of operation
// R1 - Mono select bit 6, resets stereo
// R2 - Mono drives left signal to both speakers
// R3 - Three-bit boost field, reset 011
// R4 - One boost applies to both speakers
// R5 - Host keeps boost fixed while speakers on
// R6 - Outputs shorted until short release set
// R7 - Left bits 7:4, right bits 3:0
// R8 - Host sets input stage first
// R9 - Host waits 20us before middle stage
// R10 - Host sets middle stage before offset correction
// R11 - Host sets output stage after correction
// R12 - Host waits 20us, then releases shorts
// R13 - Host shorts, waits, clears stages together
// R14 - Default sequencer normally drives these fields
// R15 - Bits act directly, no ordering enforced
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module hp_spk_output_stage_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave
  input wire spk_hp_pkg::wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Speaker audio in
  input wire logic [15:0] spk_left_in,
  input wire logic [15:0] spk_right_in,
  // Speaker drive
  output logic [15:0] spk_left_drive,
  output logic [15:0] spk_right_drive,
  output spk_hp_pkg::speaker_ctrl_type spk_left_ctrl,
  output spk_hp_pkg::speaker_ctrl_type spk_right_ctrl,
  // Left headphone stages
  output logic left_input_stage_en,
  output logic left_middle_stage_en,
  output logic left_output_stage_en,
  output logic left_phones_out_short,
  // Right headphone stages
  output logic right_input_stage_en,
  output logic right_middle_stage_en,
  output logic right_output_stage_en,
  output logic right_phones_out_short
);
  import spk_hp_pkg::*;


  // Speaker configuration state
  logic mono_q, mono_d;
  logic [2:0] boost_q, boost_d;
  logic [4:0] gain_q, gain_d;

  // Headphone stage state
  hp_channel_type left_q, left_d, right_q, right_d;

  // Bus answer state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // Speaker sample state
  logic [15:0] spk_l_q, spk_l_d, spk_r_q, spk_r_d;
  speaker_ctrl_type spk_ctrl;

  // Request qualifiers
  logic req, wr_req, rd_req;
  logic sel_spk, sel_hp, wr_spk, wr_hp;

  // Gain in half-dB units for a boost code
  function automatic logic [4:0] boost_gain(input logic [2:0] code);
    if (code == boost_top_code) begin
      boost_gain = boost_top_gain;
    end else begin
      boost_gain = 5'(code) * boost_step_gain;
    end
  endfunction

  // Word address match with no stray bits
  function automatic logic hit(input logic [31:0] adr, input logic [7:0] reg_idx);
    hit = (adr[adr_lsb +: idx_w] == reg_idx) && (adr[31:adr_lsb+idx_w] == '0) && (adr[adr_lsb-1:0] == '0);
  endfunction

  // Request decode
  always_comb begin
    req = wb_req.cyc & wb_req.stb & ~ack_q;
    wr_req = req & wb_req.we & wb_req.sel[0];
    rd_req = req & ~wb_req.we;
    sel_spk = hit(wb_req.adr, speaker_driver_config_idx);
    sel_hp = hit(wb_req.adr, headphone_stage_control_idx);
    wr_spk = wr_req & sel_spk;
    wr_hp = wr_req & sel_hp;
  end

  // Speaker configuration next values
  always_comb begin
    mono_d = mono_q;
    boost_d = boost_q;
    if (wr_spk) begin
      mono_d = wb_req.dat[mono_bit]; // see R1
      boost_d = wb_req.dat[boost_lsb +: boost_w]; // see R3
    end
    gain_d = boost_gain(boost_d); // see R3
  end

  // Speaker configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mono_q <= mono_reset; // see R1
      boost_q <= boost_reset; // see R3
      gain_q <= boost_reset_gain; // see R3
    end else begin
      mono_q <= mono_d;
      boost_q <= boost_d;
      gain_q <= gain_d;
    end
  end

  // Headphone stage next values
  always_comb begin
    left_d = left_q;
    right_d = right_q;
    if (wr_hp) begin
      left_d = wb_req.dat[left_grp_lsb +: grp_w]; // see R7
      right_d = wb_req.dat[right_grp_lsb +: grp_w]; // see R7
    end
  end

  // Headphone stage registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= grp_reset; // see R6
      right_q <= grp_reset; // see R6
    end else begin
      left_q <= left_d; // see R15
      right_q <= right_d; // see R15
    end
  end

  // Bus answer next values
  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    if (rd_req) begin
      rdat_d = '0;
      if (sel_spk) begin
        rdat_d[mono_bit] = mono_q;
        rdat_d[boost_lsb +: boost_w] = boost_q;
      end else if (sel_hp) begin
        rdat_d[left_grp_lsb +: grp_w] = left_q;
        rdat_d[right_grp_lsb +: grp_w] = right_q;
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Speaker sample next values
  always_comb begin
    spk_l_d = spk_left_in;
    if (mono_q) begin
      spk_r_d = spk_left_in; // see R2
    end else begin
      spk_r_d = spk_right_in;
    end
  end

  // Speaker sample registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spk_l_q <= '0;
      spk_r_q <= '0;
    end else begin
      spk_l_q <= spk_l_d;
      spk_r_q <= spk_r_d;
    end
  end

  // One control word for both speakers
  always_comb begin
    spk_ctrl.mono_speaker_select = mono_q;
    spk_ctrl.speaker_ac_boost = boost_q;
    spk_ctrl.boost_gain_half_db = gain_q; // see R3
  end

  // Bus outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Speaker outputs
  assign spk_left_drive = spk_l_q;
  assign spk_right_drive = spk_r_q;
  assign spk_left_ctrl = spk_ctrl; // see R4
  assign spk_right_ctrl = spk_ctrl; // see R4

  // Left channel stages
  hp_channel_stage left_stage (
    .fields(left_q),
    .input_stage_on(left_input_stage_en),
    .middle_stage_on(left_middle_stage_en),
    .output_stage_on(left_output_stage_en),
    .short_to_ground(left_phones_out_short)
  );

  // Right channel stages
  hp_channel_stage right_stage (
    .fields(right_q),
    .input_stage_on(right_input_stage_en),
    .middle_stage_on(right_middle_stage_en),
    .output_stage_on(right_output_stage_en),
    .short_to_ground(right_phones_out_short)
  );
endmodule

// File: include/spk_hp_pkg.sv
// Package for the speaker and headphone output stage control block
// Assumes a 32-bit classic Wishbone slave with word-aligned registers
package spk_hp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] speaker_driver_config_idx = 8'h33;
  localparam logic [7:0] headphone_stage_control_idx = 8'h45;
  localparam int unsigned adr_lsb = 2;
  localparam int unsigned idx_w = 8;

  // Speaker driver config fields
  localparam int unsigned mono_bit = 6;
  localparam int unsigned boost_lsb = 0;
  localparam int unsigned boost_w = 3;
  localparam logic [2:0] boost_reset = 3'h3;
  localparam logic mono_reset = 1'b0;

  // Headphone stage control fields
  localparam int unsigned left_grp_lsb = 4;
  localparam int unsigned right_grp_lsb = 0;
  localparam int unsigned grp_w = 4;
  localparam logic [3:0] grp_reset = 4'h0;

  // Boost gain in half-dB steps for each code
  localparam logic [4:0] boost_top_gain = 5'h18;
  localparam logic [2:0] boost_top_code = 3'h7;
  localparam logic [4:0] boost_step_gain = 5'h3;
  localparam logic [4:0] boost_reset_gain = 5'h9;

  typedef struct packed {
    logic short_release;
    logic output_stage_en;
    logic middle_stage_en;
    logic input_stage_en;
  } hp_channel_type;

  typedef struct packed {
    logic mono_speaker_select;
    logic [2:0] speaker_ac_boost;
    logic [4:0] boost_gain_half_db;
  } speaker_ctrl_type;

  typedef struct packed {
    logic [31:0] dat;
    logic [31:0] adr;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_type;
endpackage
